// >>> testbench/dcc_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_bus_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire dcc_pkg::dcc_bus_req_type bus_req,
  input wire logic [3:0] lat,
  output logic bus_done
);
  logic [3:0] cnt_q;
  logic gap_q;
  // ==========================================================
  // answer each access after lat idle cycles, one pulse each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      gap_q <= 1'b0;
      bus_done <= 1'b0;
    end else begin
      gap_q <= bus_done;
      bus_done <= 1'b0;
      if (bus_req.valid && !bus_done && !gap_q) begin
        if (cnt_q >= lat) begin
          bus_done <= 1'b1;
          cnt_q <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule : dcc_bus_model
`default_nettype wire

// >>> testbench/dcc_channel_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_channel_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire dcc_pkg::dcc_bus_req_type bus_req,
  input wire logic bus_hold,
  input wire logic bus_read_level,
  input wire logic ack_final_only,
  input wire logic bus_done,
  input wire logic irq
);
  logic [31:0] ctl_q;
  logic wide_q;
  // ==========================================================
  // shadow of software control writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_q <= 32'h0000_0000;
    else if (psel && penable && pwrite && paddr == dcc_pkg::OFS_CONTROL) ctl_q <= pwdata;
  end
  // shadow of the count width select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wide_q <= 1'b0;
    else if (psel && penable && pwrite && paddr == dcc_pkg::OFS_MODE) wide_q <= pwdata[0];
  end
  // ==========================================================
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    bus_req.valid && !bus_done;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_req_held: assert property (s_wait |=> bus_req.valid && $stable(bus_req.address))
    else $error("bus request dropped early");
  a_single_level: assert property (bus_req.valid && ctl_q[24] |-> bus_read_level == ctl_q[23])
    else $error("single access level wrong");
  a_dual_level: assert property (bus_req.valid && !ctl_q[24] |-> bus_read_level == !bus_req.is_write)
    else $error("dual access level wrong");
  a_src_width: assert property (bus_req.valid && !bus_req.is_write && !ctl_q[24]
    |-> bus_req.width == ctl_q[21:20])
    else $error("read width wrong");
  a_dst_width: assert property (bus_req.valid && bus_req.is_write |-> bus_req.width == ctl_q[18:17])
    else $error("write width wrong");
  a_hold_bw_zero: assert property (bus_hold |-> ctl_q[27:25] == 3'b000)
    else $error("hold without priority code");
  a_ack_wide: assert property (ack_final_only |-> (ctl_q[15] && wide_q) || $past(ctl_q[15] && wide_q))
    else $error("ack type outside wide mode");
  a_irq_enabled: assert property (irq |-> ctl_q[31] || $past(ctl_q[31]))
    else $error("interrupt while disabled");
endmodule : dcc_channel_asserts
`default_nettype wire

// >>> testbench/dcc_channel_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_channel_tb;
  logic pclk, presetn, psel, penable, pwrite, ext_pin, pready, pslverr;
  logic bus_hold, rd_lvl, ack_fo, bus_done, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] lat;
  dcc_pkg::dcc_bus_req_type bus_req;
  int n_mismatch, checks;
  logic [31:0] rq[$];
  logic [31:0] wq[$];
  localparam logic [1:0] CODE[4] = '{2'b01, 2'b10, 2'b00, 2'b11};
  localparam logic [31:0] STEP[4] = '{32'h1, 32'h2, 32'h4, 32'h10};
  localparam logic [31:0] GO = 32'h0001_0000;
  dcc_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_request_pin(ext_pin), .bus_req(bus_req),
    .bus_hold(bus_hold), .bus_read_level(rd_lvl), .ack_final_only(ack_fo),
    .bus_done(bus_done), .irq(irq));
  dcc_bus_model i_mem (.pclk(pclk), .presetn(presetn), .bus_req(bus_req), .lat(lat),
    .bus_done(bus_done));
  // ==========================================================
  always #4 pclk = ~pclk;
  // log finished accesses by direction
  always @(posedge pclk) begin
    if (bus_req.valid === 1'b1 && bus_done === 1'b1) begin
      if (bus_req.is_write) wq.push_back(bus_req.address);
      else rq.push_back(bus_req.address);
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, then one idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task wait_done;
    int k;
    k = 0;
    do begin
      apb(1'b0, dcc_pkg::OFS_STATUS, 32'h0);
      k++;
    end while (rd[0] !== 1'b1 && k < 200);
  endtask : wait_done
  task complete_run;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // ==========================================================
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, ext_pin} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lat = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, dcc_pkg::OFS_BYTE_COUNT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h3f0, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, dcc_pkg::OFS_CONTROL, GO);
    apb(1'b0, dcc_pkg::OFS_CONTROL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, dcc_pkg::OFS_STATUS, 32'h1);
    // misaligned word count: error, no access
    apb(1'b1, dcc_pkg::OFS_BYTE_COUNT, 32'h3);
    apb(1'b1, dcc_pkg::OFS_CONTROL, GO | 32'h0054_0000);
    apb(1'b0, dcc_pkg::OFS_STATUS, 32'h0);
    chk(rd[6], 1'b1);
    chk(rq.size() + wq.size(), 0);
    apb(1'b1, dcc_pkg::OFS_STATUS, 32'h1);
    apb(1'b0, dcc_pkg::OFS_STATUS, 32'h0);
    chk(rd[6], 1'b0);
    // each width, continuous, source stepping only
    for (int i = 0; i < 4; i++) begin
      rq.delete();
      wq.delete();
      lat <= 4'(i * 2);
      apb(1'b1, dcc_pkg::OFS_SRC_ADDRESS, 32'h1000);
      apb(1'b1, dcc_pkg::OFS_DST_ADDRESS, 32'h2000);
      apb(1'b1, dcc_pkg::OFS_BYTE_COUNT, STEP[i] * 2);
      apb(1'b1, dcc_pkg::OFS_CONTROL, GO | 32'h0040_0000 | {CODE[i], 20'h0} | {CODE[i], 17'h0});
      wait_done();
      chk(rd[0], 1'b1);
      chk(wq.size(), 2);
      chk(rq[1], 32'h1000 + STEP[i]);
      chk(wq[1], 32'h2000);
      chk(irq, 1'b0);
      apb(1'b0, dcc_pkg::OFS_BYTE_COUNT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, dcc_pkg::OFS_STATUS, 32'h1);
    end
    // cycle steal: software start, gated pin, enabled pin
    wq.delete();
    apb(1'b1, dcc_pkg::OFS_BYTE_COUNT, 32'h8);
    apb(1'b1, dcc_pkg::OFS_CONTROL, GO | 32'h2040_0000);
    repeat (40) @(posedge pclk);
    apb(1'b0, dcc_pkg::OFS_BYTE_COUNT, 32'h0);
    chk(rd, 32'h4);
    ext_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_pin <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(wq.size(), 1);
    // pin raised only with no software start pending, so they never collide
    apb(1'b1, dcc_pkg::OFS_CONTROL, 32'he040_0000);
    ext_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_pin <= 1'b0;
    wait_done();
    chk(wq.size(), 2);
    chk(irq, 1'b1);
    apb(1'b1, dcc_pkg::OFS_STATUS, 32'h1);
    @(posedge pclk);
    chk(irq, 1'b0);
    // single address, read level low
    rq.delete();
    wq.delete();
    apb(1'b1, dcc_pkg::OFS_BYTE_COUNT, 32'h4);
    apb(1'b1, dcc_pkg::OFS_CONTROL, GO | 32'h0100_0000);
    wait_done();
    chk(rq.size() + wq.size(), 1);
    apb(1'b1, dcc_pkg::OFS_STATUS, 32'h1);
    // auto-align: long source, byte destination, no step bits
    rq.delete();
    wq.delete();
    apb(1'b1, dcc_pkg::OFS_SRC_ADDRESS, 32'h1000);
    apb(1'b1, dcc_pkg::OFS_DST_ADDRESS, 32'h2000);
    apb(1'b1, dcc_pkg::OFS_BYTE_COUNT, 32'h8);
    apb(1'b1, dcc_pkg::OFS_CONTROL, GO | 32'h1002_0000);
    wait_done();
    chk(rq[1], 32'h1004);
    chk(wq[1], 32'h2000);
    apb(1'b1, dcc_pkg::OFS_STATUS, 32'h1);
    // acknowledge type needs wide count mode
    apb(1'b1, dcc_pkg::OFS_CONTROL, 32'h0000_8000);
    chk(ack_fo, 1'b0);
    apb(1'b1, dcc_pkg::OFS_MODE, 32'h1);
    apb(1'b1, dcc_pkg::OFS_CONTROL, 32'h0000_8000);
    @(posedge pclk);
    chk(ack_fo, 1'b1);
    complete_run();
  end
endmodule : dcc_channel_tb
bind dcc_channel dcc_channel_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .bus_req(bus_req), .bus_hold(bus_hold), .bus_read_level(bus_read_level),
  .ack_final_only(ack_final_only), .bus_done(bus_done), .irq(irq));
`default_nettype wire

// >>> verilog/dcc_channel.sv
// Function
// - set block-done when the whole programmed block has been transferred
// - on start, count not a multiple of access size: set error, no transfer
// - control bit 31 enables the interrupt on completion or error
// - control bit 30 gates the external request pin
// - software start bit starts a transfer when idle with a valid count, whatever bit 30 is
// - bit 29 clear: transfers run back to back until count is zero
// - cycle-steal: exactly one read/write transfer per request
// - auto-align source when source width not smaller, else destination
// - auto-aligned side address increments even without its step bit
// - release bus when count reaches a multiple of the bandwidth block
// - codes 001..111 give 512..32768 or 16384..1048576 byte blocks
// - code 000 keeps bus request until the whole transfer completes
// - bit 24 selects dual (0) or single (1) address mode
// - single mode drives only source address and a direction level
// - bit 23 is the read level driven in single-address accesses
// - bit 22 steps source address by access size after each transfer
// - bit 19 steps destination address by access size after each transfer
// - bits 21-20 source width: 00 long, 01 byte, 10 word, 11 line
// - bits 18-17 destination width with the same encoding
// - acknowledge-type bit exists only in wide count mode
// - count drops by access size after dual write or any single access
// - start bit self-clears after one clock, always reads zero
// - error flag clears on reset or writing one to block-done
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module dcc_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_request_pin,
  output dcc_pkg::dcc_bus_req_type bus_req,
  output logic bus_hold,
  output logic bus_read_level,
  output logic ack_final_only,
  input wire logic bus_done,
  output logic irq
);

  // ==========================================================================
  // helpers
  // ==========================================================================
  // access size in bytes for a width code
  function automatic logic [4:0] size_of(input logic [1:0] w);
    case (w)
      2'b01: size_of = 5'h01;
      2'b10: size_of = 5'h02;
      2'b00: size_of = 5'h04;
      default: size_of = 5'h10;
    endcase
  endfunction : size_of

  // rank so that byte < word < long < line
  function automatic logic [1:0] rank_of(input logic [1:0] w);
    case (w)
      2'b01: rank_of = 2'h0;
      2'b10: rank_of = 2'h1;
      2'b00: rank_of = 2'h2;
      default: rank_of = 2'h3;
    endcase
  endfunction : rank_of

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_GAP
  } dcc_state_type;

  // ==========================================================================
  // registers
  // ==========================================================================
  logic [31:0] control_q;
  logic [31:0] src_address_q;
  logic [31:0] dst_address_q;
  logic [23:0] count_q;
  logic wide_count_select_q;
  logic done_q;
  logic ce_q;
  logic busy_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic start_q;
  logic steal_q;
  dcc_state_type state_q;

  logic acc;
  logic wr;
  logic [31:0] wmask;
  logic start_wr;
  logic ext_req;
  logic trigger;
  logic [1:0] xfer_width;
  logic [4:0] xsize;
  logic [23:0] count_d;
  logic count_bad;
  logic src_step;
  logic dst_step;
  logic step_done;
  logic last;
  logic [23:0] bw_block;
  logic bw_release;
  logic [2:0] bw_code;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign start_wr = wr && (paddr == dcc_pkg::OFS_CONTROL) && pwdata[dcc_pkg::CTL_START];
  // a start and a pin request in one cycle merge into one trigger
  assign ext_req = control_q[dcc_pkg::CTL_EXT] && ext_s2_q;
  assign trigger = start_q || ext_req;
  // acknowledge-type bit kept only in wide count mode
  assign wmask = wide_count_select_q ? 32'hfffe_8000 : 32'hfffe_0000;

  // the counted access width is the larger of the two sides
  assign xfer_width = (rank_of(control_q[dcc_pkg::CTL_SSZ_HI:dcc_pkg::CTL_SSZ_LO])
                       >= rank_of(control_q[dcc_pkg::CTL_DSZ_HI:dcc_pkg::CTL_DSZ_LO]))
                      ? control_q[dcc_pkg::CTL_SSZ_HI:dcc_pkg::CTL_SSZ_LO]
                      : control_q[dcc_pkg::CTL_DSZ_HI:dcc_pkg::CTL_DSZ_LO];
  assign xsize = size_of(xfer_width);
  assign count_bad = (count_q == 24'h00_0000) || ((count_q & {19'h0_0000, xsize - 5'h01}) != 24'h00_0000);
  assign count_d = count_q - {19'h0_0000, xsize};
  assign last = (count_d == 24'h00_0000);

  // auto-align picks the wider side; source wins a tie
  assign src_step = control_q[dcc_pkg::CTL_SRC_ADDR_STEP] ||
                    (control_q[dcc_pkg::CTL_AA] && xfer_width == control_q[dcc_pkg::CTL_SSZ_HI:dcc_pkg::CTL_SSZ_LO]);
  assign dst_step = control_q[dcc_pkg::CTL_DST_ADDR_STEP] ||
                    (control_q[dcc_pkg::CTL_AA] && xfer_width != control_q[dcc_pkg::CTL_SSZ_HI:dcc_pkg::CTL_SSZ_LO]);

  // one access counts when the write (dual) or the single access completes
  assign step_done = bus_done && ((state_q == ST_WRITE) ||
                     (state_q == ST_READ && control_q[dcc_pkg::CTL_SAA]));

  // bandwidth block: code 001 is the base, each step doubles
  assign bw_code = control_q[dcc_pkg::CTL_BW_HI:dcc_pkg::CTL_BW_LO];
  assign bw_block = (24'h00_0001 << (wide_count_select_q ? dcc_pkg::BW_BASE_SHIFT_WIDE
                     : dcc_pkg::BW_BASE_SHIFT_SHORT)) << (bw_code - 3'h1);
  assign bw_release = (bw_code != 3'h0) && ((count_d & (bw_block - 24'h00_0001)) == 24'h00_0000);

  // ==========================================================================
  // pin synchroniser
  // ==========================================================================
  // the request pin is asynchronous to pclk; only the second flop is read
  // by the trigger logic, so a metastable first stage never reaches state
  // a pin pulse shorter than one clock may be missed entirely
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= external_request_pin;
      ext_s2_q <= ext_s1_q;
    end
  end

  // ==========================================================================
  // control and mode registers
  // ==========================================================================
  // the start bit is never stored in control_q, so a read returns zero;
  // start_q delays the request by one clock so that the new control fields
  // are already in place when the sequencer looks at them
  // the acknowledge-type bit is dropped at write time in short count mode:
  // switching to wide mode later does not revive an earlier value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= dcc_pkg::CONTROL_RESET;
      wide_count_select_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= start_wr;
      if (wr && paddr == dcc_pkg::OFS_CONTROL) begin
        control_q <= pwdata & wmask & ~(32'h1 << dcc_pkg::CTL_START);
      end
      if (wr && paddr == dcc_pkg::OFS_MODE) begin
        wide_count_select_q <= pwdata[0];
      end
    end
  end

  // ==========================================================================
  // transfer sequencer, addresses and count
  // ==========================================================================
  // address and count writes are ignored outside idle so that a running
  // transfer cannot be corrupted halfway; software must wait for done
  // dual mode runs read then write per access, single mode one access only
  // the gap state releases the bus between bandwidth blocks and, in
  // cycle-steal mode with a nonzero bandwidth code, between requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      src_address_q <= dcc_pkg::ADDRESS_RESET;
      dst_address_q <= dcc_pkg::ADDRESS_RESET;
      count_q <= dcc_pkg::COUNT_RESET;
      busy_q <= 1'b0;
      steal_q <= 1'b0;
    end else begin
      if (wr && paddr == dcc_pkg::OFS_SRC_ADDRESS && state_q == ST_IDLE) begin
        src_address_q <= pwdata;
      end
      if (wr && paddr == dcc_pkg::OFS_DST_ADDRESS && state_q == ST_IDLE) begin
        dst_address_q <= pwdata;
      end
      if (wr && paddr == dcc_pkg::OFS_BYTE_COUNT && state_q == ST_IDLE) begin
        count_q <= wide_count_select_q ? pwdata[23:0] : {8'h00, pwdata[15:0]};
      end
      case (state_q)
        ST_IDLE: begin
          if (trigger && !count_bad) begin
            state_q <= ST_READ;
            busy_q <= 1'b1;
            steal_q <= control_q[dcc_pkg::CTL_CS];
          end
        end
        ST_READ: begin
          if (bus_done) begin
            if (src_step) begin
              src_address_q <= src_address_q + {27'h0, xsize};
            end
            if (control_q[dcc_pkg::CTL_SAA]) begin
              count_q <= count_d;
              state_q <= last ? ST_IDLE : (steal_q || bw_release) ? ST_GAP : ST_READ;
              busy_q <= !last;
            end else begin
              state_q <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (bus_done) begin
            if (dst_step) begin
              dst_address_q <= dst_address_q + {27'h0, xsize};
            end
            count_q <= count_d;
            state_q <= last ? ST_IDLE : (steal_q || bw_release) ? ST_GAP : ST_READ;
            busy_q <= !last;
          end
        end
        ST_GAP: begin
          // bus released; cycle-steal waits for a fresh request
          if (!steal_q || trigger) begin
            state_q <= ST_READ;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // status flags: hardware set wins over software clear
  // ==========================================================================
  // a clear that lands in the cycle of the setting event is lost on purpose,
  // so software never misses a completion it did not see
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      ce_q <= 1'b0;
    end else begin
      if (step_done && last) begin
        done_q <= 1'b1;
      end else if (wr && paddr == dcc_pkg::OFS_STATUS && pwdata[dcc_pkg::STS_DONE]) begin
        done_q <= 1'b0;
      end
      if (state_q == ST_IDLE && trigger && count_bad) begin
        ce_q <= 1'b1;
      end else if (wr && paddr == dcc_pkg::OFS_STATUS && pwdata[dcc_pkg::STS_DONE]) begin
        ce_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // bus side outputs
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_req <= '0;
      bus_hold <= 1'b0;
      bus_read_level <= 1'b1;
      ack_final_only <= 1'b0;
      irq <= 1'b0;
    end else begin
      bus_req.valid <= (state_q == ST_READ || state_q == ST_WRITE) && !bus_done;
      bus_req.is_write <= (state_q == ST_WRITE);
      // single mode drives the source address only
      bus_req.address <= (state_q == ST_WRITE) ? dst_address_q : src_address_q;
      bus_req.width <= (state_q == ST_WRITE) ? control_q[dcc_pkg::CTL_DSZ_HI:dcc_pkg::CTL_DSZ_LO]
                       : control_q[dcc_pkg::CTL_SSZ_HI:dcc_pkg::CTL_SSZ_LO];
      // priority mode holds the bus through the gap states too
      bus_hold <= busy_q && (bw_code == 3'h0);
      bus_read_level <= control_q[dcc_pkg::CTL_SAA] ? control_q[dcc_pkg::CTL_SRW]
                        : (state_q != ST_WRITE);
      ack_final_only <= wide_count_select_q && control_q[dcc_pkg::CTL_ACK];
      irq <= control_q[dcc_pkg::CTL_INT] && (done_q || ce_q);
    end
  end

  // ==========================================================================
  // apb slave: zero wait states, unmapped reads zero with pslverr
  // ==========================================================================
  // read data and ready are registered in the setup cycle and stand for
  // exactly the access cycle; the master must not stretch setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          dcc_pkg::OFS_SRC_ADDRESS: prdata <= src_address_q;
          dcc_pkg::OFS_DST_ADDRESS: prdata <= dst_address_q;
          dcc_pkg::OFS_CONTROL: prdata <= control_q;
          dcc_pkg::OFS_BYTE_COUNT: prdata <= {8'h00, count_q};
          dcc_pkg::OFS_STATUS: prdata <= {25'h0, ce_q, 3'h0, (state_q == ST_GAP), busy_q, done_q};
          dcc_pkg::OFS_MODE: prdata <= {31'h0, wide_count_select_q};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule : dcc_channel
`default_nettype wire

// >>> verilog/dcc_pkg.sv
package dcc_pkg;

  // ==========================================================================
  // register offsets (byte addresses on apb)
  // ==========================================================================
  localparam logic [11:0] OFS_SRC_ADDRESS = 12'h300;
  localparam logic [11:0] OFS_DST_ADDRESS = 12'h304;
  localparam logic [11:0] OFS_CONTROL = 12'h308;
  localparam logic [11:0] OFS_BYTE_COUNT = 12'h30c;
  localparam logic [11:0] OFS_STATUS = 12'h310;
  localparam logic [11:0] OFS_MODE = 12'h318;

  // ==========================================================================
  // control field positions
  // ==========================================================================
  localparam int CTL_INT = 31;
  localparam int CTL_EXT = 30;
  localparam int CTL_CS = 29;
  localparam int CTL_AA = 28;
  localparam int CTL_BW_HI = 27;
  localparam int CTL_BW_LO = 25;
  localparam int CTL_SAA = 24;
  localparam int CTL_SRW = 23;
  localparam int CTL_SRC_ADDR_STEP = 22;
  localparam int CTL_SSZ_HI = 21;
  localparam int CTL_SSZ_LO = 20;
  localparam int CTL_DST_ADDR_STEP = 19;
  localparam int CTL_DSZ_HI = 18;
  localparam int CTL_DSZ_LO = 17;
  localparam int CTL_START = 16;
  localparam int CTL_ACK = 15;

  // ==========================================================================
  // status field positions and reset values
  // ==========================================================================
  localparam int STS_DONE = 0;
  localparam int STS_BSY = 1;
  localparam int STS_REQ = 2;
  localparam int STS_CE = 6;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [23:0] COUNT_RESET = 24'h00_0000;
  localparam logic [31:0] ADDRESS_RESET = 32'h0000_0000;

  // ==========================================================================
  // log2 of the block sizes for bandwidth code 001 (each further code doubles)
  // ==========================================================================
  localparam int BW_BASE_SHIFT_SHORT = 9;
  localparam int BW_BASE_SHIFT_WIDE = 14;

  // width encoding of src_width / dst_width
  typedef enum logic [1:0] {
    DCC_LONG = 2'b00,
    DCC_BYTE = 2'b01,
    DCC_WORD = 2'b10,
    DCC_LINE = 2'b11
  } dcc_width_type;

  // bus request toward the system bus master
  typedef struct packed {
    logic valid;
    logic is_write;
    logic [31:0] address;
    logic [1:0] width;
  } dcc_bus_req_type;

endpackage : dcc_pkg
